/* File: hw/pll_fd_pkg.sv */
// constants for the pll status and fine delay register bank
// assumes an apb master with 32-bit data, one register per aligned word
// Overview of operation
// - vco threshold bit reads 1 above monitor threshold, 0 below
// - vco threshold result sits at status bit 3
// - status bit 2 reads 1 when second reference exceeds threshold
// - status bit 1 reads 1 when first reference exceeds threshold
// - both reference comparisons use threshold chosen by config 0x01A bit 6
// - status bit 0 is the digital lock detector result
// - 0x0A0 bit 0 bypasses the fine delay; not bypassed after reset
// - ramp capacitor field bits 5:3 selects count, 000 gives 4
// - ramp current field bits 2:0 sets current, 000 gives 200 ua
// - delay full scale follows capacitor count and ramp current jointly
package pll_fd_pkg;
    localparam logic [11:0] thr_cfg_idx = 12'h01a;
    localparam logic [11:0] bypass_idx = 12'h0a0;
    localparam logic [11:0] ramp_idx = 12'h0a1;
    localparam logic [11:0] status_idx = 12'h01f;
    localparam logic [11:0] irq_stat_idx = 12'h100;
    localparam logic [11:0] irq_mask_idx = 12'h101;
    localparam int thr_sel_bit = 6;
    localparam int vco_bit = 3;
    localparam int second_reference_input_bit = 2;
    localparam int first_reference_input_bit = 1;
    localparam int lock_bit = 0;
    localparam logic [7:0] thr_cfg_rst = 8'h00;
    localparam logic [7:0] bypass_rst = 8'h00;
    localparam logic [7:0] ramp_rst = 8'h00;
    localparam logic [3:0] irq_rst = 4'h0;
    localparam logic [10:0] cur_step_ua = 11'd200;
endpackage

/* File: hw/pll_status_fine_delay_regs.sv */
// apb register bank: pll monitor status, fine delay control, event interrupts
// assumes monitor inputs already synchronous to mclk_i
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
module pll_status_fine_delay_regs (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic vco_above_thr_i,
    input wire logic first_reference_input_above_lo_i,
    input wire logic first_reference_input_above_hi_i,
    input wire logic second_reference_input_above_lo_i,
    input wire logic second_reference_input_above_hi_i,
    input wire logic pll_locked_i,
    output logic thr_sel_o,
    output logic delay_bypass_o,
    output logic [2:0] ramp_cap_count_o,
    output logic [10:0] ramp_current_ua_o,
    output logic [13:0] delay_full_scale_o,
    output logic irq_o
);
    logic [7:0] thr_cfg;
    logic [7:0] delay_bypass_ctrl;
    logic [7:0] delay_ramp_setup;
    logic [3:0] status_q;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] next_prdata;
    logic slverr_q;

    function automatic logic [2:0] cap_count(input logic [2:0] code);
        // four minus the number of set bits, four when all clear
        logic [1:0] ones;
        ones = 2'(code[0]) + 2'(code[1]) + 2'(code[2]);
        cap_count = (code == 3'b000) ? 3'd4 : 3'(3'd4 - 3'(ones));
    endfunction

    function automatic logic is_reg(input logic [15:0] a, input logic [11:0] idx);
        is_reg = (a[1:0] == 2'b00) && (a[15:2] == {2'b00, idx});
    endfunction

    wire access = psel_i && penable_i;
    wire wr = access && pwrite_i;
    wire hit_thr = is_reg(paddr_i, pll_fd_pkg::thr_cfg_idx);
    wire hit_byp = is_reg(paddr_i, pll_fd_pkg::bypass_idx);
    wire hit_ramp = is_reg(paddr_i, pll_fd_pkg::ramp_idx);
    wire hit_stat = is_reg(paddr_i, pll_fd_pkg::status_idx);
    wire hit_istat = is_reg(paddr_i, pll_fd_pkg::irq_stat_idx);
    wire hit_imask = is_reg(paddr_i, pll_fd_pkg::irq_mask_idx);
    wire mapped = hit_thr | hit_byp | hit_ramp | hit_stat | hit_istat | hit_imask;

    // threshold select chooses which reference comparison is reported
    wire sel = thr_cfg[pll_fd_pkg::thr_sel_bit];
    wire first_reference_input_now = sel ? first_reference_input_above_hi_i : first_reference_input_above_lo_i;
    wire second_reference_input_now = sel ? second_reference_input_above_hi_i : second_reference_input_above_lo_i;
    wire [3:0] status_now = {vco_above_thr_i, second_reference_input_now, first_reference_input_now, pll_locked_i};
    // an event is any change of a status bit
    wire [3:0] events = status_now ^ status_q;
    wire [3:0] w1c = (wr && hit_istat) ? pwdata_i[3:0] : 4'h0;
    wire [7:0] wr_byte = pwdata_i[7:0];
    wire [3:0] wr_nib = pwdata_i[3:0];
    wire wr_sel_bit = pwdata_i[pll_fd_pkg::thr_sel_bit];

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            thr_cfg <= pll_fd_pkg::thr_cfg_rst;
            delay_bypass_ctrl <= pll_fd_pkg::bypass_rst;
            delay_ramp_setup <= pll_fd_pkg::ramp_rst;
            irq_mask <= pll_fd_pkg::irq_rst;
        end else if (wr) begin
            if (hit_thr) begin
                thr_cfg <= wr_byte;
            end
            if (hit_byp) begin
                delay_bypass_ctrl <= wr_byte;
            end
            if (hit_ramp) begin
                delay_ramp_setup <= wr_byte;
            end
            if (hit_imask) begin
                irq_mask <= wr_nib;
            end
            // status register has no write path
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            status_q <= pll_fd_pkg::irq_rst;
            irq_stat <= pll_fd_pkg::irq_rst;
        end else begin
            status_q <= status_now;
            // set wins over a simultaneous write-one clear
            irq_stat <= (irq_stat & ~w1c) | events;
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_thr) begin
            next_prdata[7:0] = thr_cfg;
        end
        if (hit_byp) begin
            next_prdata[7:0] = delay_bypass_ctrl;
        end
        if (hit_ramp) begin
            next_prdata[7:0] = delay_ramp_setup;
        end
        if (hit_stat) begin
            next_prdata[3:0] = status_now;
        end
        if (hit_istat) begin
            next_prdata[3:0] = irq_stat;
        end
        if (hit_imask) begin
            next_prdata[3:0] = irq_mask;
        end
    end

    // read data registered in the setup cycle, answered in the first access cycle
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prdata_o <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
            slverr_q <= !mapped;
        end
    end

    assign pready_o = 1'b1;
    assign pslverr_o = access && slverr_q;
    assign irq_o = |(irq_stat & irq_mask);
    assign thr_sel_o = sel;
    assign delay_bypass_o = delay_bypass_ctrl[0];
    assign ramp_cap_count_o = cap_count(delay_ramp_setup[5:3]);
    wire [2:0] cur_code = delay_ramp_setup[2:0];
    wire [10:0] cur_steps = {8'h00, cur_code} + 11'd1;
    wire [13:0] fs_num = 14'(ramp_cap_count_o) * 14'd1600;
    // 200 ua steps per code
    assign ramp_current_ua_o = 11'(pll_fd_pkg::cur_step_ua * cur_steps);
    // full scale is proportional to capacitance over current: caps*1600/current_steps
    assign delay_full_scale_o = fs_num / 14'(cur_steps);

    a_status_live: assert property (@(posedge mclk_i) disable iff (srst_i)
        psel_i && !penable_i && !pwrite_i && hit_stat |=> prdata_o[3:0] == $past(status_now))
        else $error("status read mismatch");
    a_ref_select: assert property (@(posedge mclk_i) disable iff (srst_i)
        status_now[pll_fd_pkg::first_reference_input_bit] == (sel ? first_reference_input_above_hi_i : first_reference_input_above_lo_i))
        else $error("first_reference_input threshold select wrong");
    a_second_reference_input_select: assert property (@(posedge mclk_i) disable iff (srst_i)
        status_now[pll_fd_pkg::second_reference_input_bit] == (sel ? second_reference_input_above_hi_i : second_reference_input_above_lo_i))
        else $error("second_reference_input threshold select wrong");
    a_vco_lock: assert property (@(posedge mclk_i) disable iff (srst_i)
        status_now[pll_fd_pkg::vco_bit] == vco_above_thr_i
        && status_now[pll_fd_pkg::lock_bit] == pll_locked_i)
        else $error("vco or lock bit wrong");
    a_bypass_reset: assert property (@(posedge mclk_i) $past(srst_i) |-> !delay_bypass_o)
        else $error("delay bypassed after reset");
    a_cap_codes: assert property (@(posedge mclk_i) disable iff (srst_i)
        (delay_ramp_setup[5:3] == 3'b000 |-> ramp_cap_count_o == 3'd4)
        and (delay_ramp_setup[5:3] == 3'b111 |-> ramp_cap_count_o == 3'd1)
        and (delay_ramp_setup[5:3] == 3'b100 |-> ramp_cap_count_o == 3'd3))
        else $error("capacitor count decode wrong");
    a_cur_codes: assert property (@(posedge mclk_i) disable iff (srst_i)
        (delay_ramp_setup[2:0] == 3'b000 |-> ramp_current_ua_o == 11'd200)
        and (delay_ramp_setup[2:0] == 3'b010 |-> ramp_current_ua_o == 11'd600))
        else $error("ramp current decode wrong");
    a_full_scale: assert property (@(posedge mclk_i) disable iff (srst_i)
        delay_ramp_setup[5:0] == 6'h00 |-> delay_full_scale_o == 14'd6400)
        else $error("full scale wrong at defaults");

    a_pready_high: assert property (@(posedge mclk_i) disable iff (srst_i)
        pready_o)
        else $error("pready not high");

    a_err_unmapped: assert property (@(posedge mclk_i) disable iff (srst_i)
        psel_i && !penable_i && !mapped |=> slverr_q)
        else $error("no error for unmapped address");

    a_err_mapped: assert property (@(posedge mclk_i) disable iff (srst_i)
        psel_i && !penable_i && mapped |=> !slverr_q)
        else $error("error for mapped address");

    a_err_idle: assert property (@(posedge mclk_i) disable iff (srst_i)
        !access |-> !pslverr_o)
        else $error("error outside access phase");

    a_rdata_unmapped: assert property (@(posedge mclk_i) disable iff (srst_i)
        psel_i && !penable_i && !mapped |=> prdata_o == 32'h0000_0000)
        else $error("unmapped read data not zero");

    a_rdata_write: assert property (@(posedge mclk_i) disable iff (srst_i)
        psel_i && !penable_i && pwrite_i |=> prdata_o == 32'h0000_0000)
        else $error("read data not zero on write");

    a_rdata_stable: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(psel_i && !penable_i) |=> $stable(prdata_o))
        else $error("read data moved outside setup");

    a_rdata_upper: assert property (@(posedge mclk_i) disable iff (srst_i)
        prdata_o[31:8] == 24'h00_0000)
        else $error("upper read data bits set");

    a_byp_write: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr && hit_byp |=> delay_bypass_ctrl == $past(wr_byte))
        else $error("bypass write lost");

    a_byp_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(wr && hit_byp) |=> $stable(delay_bypass_ctrl))
        else $error("bypass changed without write");

    a_ramp_write: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr && hit_ramp |=> delay_ramp_setup == $past(wr_byte))
        else $error("ramp write lost");

    a_ramp_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(wr && hit_ramp) |=> $stable(delay_ramp_setup))
        else $error("ramp setup changed without write");

    a_thr_write: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr && hit_thr |=> thr_sel_o == $past(wr_sel_bit))
        else $error("threshold select write lost");

    a_thr_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(wr && hit_thr) |=> $stable(thr_sel_o))
        else $error("threshold select changed without write");

    a_stat_noerr: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr && hit_stat |-> !pslverr_o)
        else $error("status write flagged as error");

    a_stat_nowrite: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr && hit_stat |=> $stable(thr_cfg) && $stable(delay_bypass_ctrl)
        && $stable(delay_ramp_setup) && $stable(irq_mask))
        else $error("status write changed a register");

    a_ramp_reset: assert property (@(posedge mclk_i)
        $past(srst_i) |-> delay_ramp_setup == 8'h00)
        else $error("ramp setup not cleared by reset");

    a_thr_reset: assert property (@(posedge mclk_i)
        $past(srst_i) |-> !thr_sel_o)
        else $error("threshold select not cleared by reset");

    a_cap_three: assert property (@(posedge mclk_i) disable iff (srst_i)
        delay_ramp_setup[5:3] inside {3'b001, 3'b010} |-> ramp_cap_count_o == 3'd3)
        else $error("capacitor count not three");

    a_cap_two: assert property (@(posedge mclk_i) disable iff (srst_i)
        delay_ramp_setup[5:3] inside {3'b011, 3'b101, 3'b110} |-> ramp_cap_count_o == 3'd2)
        else $error("capacitor count not two");

    a_cur_two: assert property (@(posedge mclk_i) disable iff (srst_i)
        delay_ramp_setup[2:0] == 3'b001 |-> ramp_current_ua_o == 11'd400)
        else $error("ramp current not 400");

    a_cur_range: assert property (@(posedge mclk_i) disable iff (srst_i)
        ramp_current_ua_o >= 11'd200 && ramp_current_ua_o <= 11'd1600)
        else $error("ramp current out of range");

    a_fs_min: assert property (@(posedge mclk_i) disable iff (srst_i)
        delay_ramp_setup[5:0] == 6'h3f |-> delay_full_scale_o == 14'd200)
        else $error("full scale wrong at top codes");

    a_irq_set: assert property (@(posedge mclk_i) disable iff (srst_i)
        events != 4'h0 |=> (irq_stat & $past(events)) == $past(events))
        else $error("event did not set status");

    a_irq_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr && hit_istat && events == 4'h0 |=> (irq_stat & $past(wr_nib)) == 4'h0)
        else $error("write one did not clear status");

    a_irq_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
        events == 4'h0 && !(wr && hit_istat) |=> $stable(irq_stat))
        else $error("interrupt status moved without cause");

    a_mask_write: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr && hit_imask |=> irq_mask == $past(wr_nib))
        else $error("mask write lost");

    a_irq_reset: assert property (@(posedge mclk_i)
        $past(srst_i) |-> irq_stat == 4'h0 && !irq_o)
        else $error("interrupt state not cleared by reset");
endmodule

/* File: dv/testbench.sv */
// apb bench for the pll status and fine delay register bank
// drives every port itself; one clock, sync reset held three cycles
`timescale 1ns/1ps
module testbench;
    logic mclk_i = 0, srst_i = 1, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic vco = 0, r1l = 0, r1h = 0, r2l = 0, r2h = 0, lock = 0, err;
    wire [31:0] prdata;
    wire pready, pslverr, thr_sel, byp, irq;
    wire [2:0] caps;
    wire [10:0] cur;
    wire [13:0] fs;
    int num_errors = 0, compares = 0;
    always #12.5 mclk_i = ~mclk_i;
    pll_status_fine_delay_regs DUT (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .vco_above_thr_i(vco),
        .first_reference_input_above_lo_i(r1l), .first_reference_input_above_hi_i(r1h), .second_reference_input_above_lo_i(r2l),
        .second_reference_input_above_hi_i(r2h), .pll_locked_i(lock), .thr_sel_o(thr_sel),
        .delay_bypass_o(byp), .ramp_cap_count_o(caps), .ramp_current_ua_o(cur),
        .delay_full_scale_o(fs), .irq_o(irq));
    task automatic close_out();
        if (num_errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // waits on pready without a bound; the bench watchdog backs it up
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_i);
        penable <= 1;
        do begin
            @(posedge mclk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask
    task automatic setmon(input logic [5:0] v);
        @(posedge mclk_i);
        {vco, r1l, r1h, r2l, r2h, lock} <= v;
        repeat (2) @(posedge mclk_i);
    endtask
    initial begin
        #100000;
        num_errors++;
        close_out();
    end
    initial begin
        logic [2:0] c;
        repeat (3) @(posedge mclk_i);
        srst_i <= 0;
        @(negedge mclk_i);
        chk("bypass_rst", byp, 0);
        chk("caps_rst", caps, 4);
        chk("cur_rst", cur, 200);
        rdchk("ramp_rst", 16'h0284, 32'h0000_0000);
        setmon(6'b110010); // vco, first_reference_input lo, second_reference_input hi only
        rdchk("status_lo", 16'h007c, 32'h0000_000a);
        apb(1, 16'h0068, 32'h0000_0040);
        setmon(6'b010111); // first_reference_input lo only, second_reference_input lo and hi, lock
        chk("thr_sel", thr_sel, 1);
        rdchk("status_hi", 16'h007c, 32'h0000_0005);
        apb(1, 16'h007c, 32'h0000_00ff);
        rdchk("status_wr", 16'h007c, 32'h0000_0005);
        apb(1, 16'h0280, 32'h0000_0001);
        @(negedge mclk_i);
        chk("bypass_set", byp, 1);
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            apb(1, 16'h0284, {26'd0, c, c});
            @(negedge mclk_i);
            chk("caps", caps, 4 - $countones(c));
            chk("cur", cur, 200 * (i + 1));
            chk("full_scale", fs, (4 - $countones(c)) * 1600 / (i + 1));
            rdchk("ramp_rb", 16'h0284, {26'd0, c, c});
        end
        apb(0, 16'h0300, 32'h0000_0000);
        chk("unmapped_err", err, 1);
        chk("unmapped_data", rd, 0);
        // events: clear, masked change, unmask raises, w1c lowers
        apb(1, 16'h0404, 32'h0000_0000);
        apb(1, 16'h0400, 32'h0000_000f);
        rdchk("irq_clr", 16'h0400, 32'h0000_0000);
        setmon(6'b010110); // lock falls
        rdchk("irq_stat", 16'h0400, 32'h0000_0001);
        chk("irq_masked", irq, 0);
        apb(1, 16'h0404, 32'h0000_0001);
        @(negedge mclk_i);
        chk("irq_on", irq, 1);
        apb(1, 16'h0400, 32'h0000_0001);
        @(negedge mclk_i);
        chk("irq_off", irq, 0);
        close_out();
    end
endmodule
